// ===== rtl/lcd_frame_ctrl.sv
// lcd screen rotation, blink and frame timing control with register port
//
// Behaviour
// RQ1 - auto-rotate set: cycle displayed screen through all four memories in turn
// RQ2 - rotation interval comes from the blink-rate code field
// RQ3 - blink enable plus auto-rotate: rotate, do not blink
// RQ4 - frame invert enable toggles polarity every other frame; clear means none
// RQ5 - software keeps the two reserved screen-control bits at zero
// RQ6 - screen-pick field selects which of screens 0 to 3 drives pins
// RQ7 - hardware sets update-done once memory is taken back and frame started
// RQ8 - memory hold set: display stops using data registers, cpu may rewrite
// RQ9 - after hold clears, data registers used again from next frame boundary
// RQ10 - blink source 00: software timing, display held off
// RQ11 - blink source 01: software timing, display held on
// RQ12 - blink source 10: display blinks at 2 Hz
// RQ13 - blink source 11: blink rate from blink-rate code
// RQ14 - blink-rate code: 1, 1/2, 1/3, 1/4 Hz, only with source 11
// RQ15 - 4-bit frame divider code, reset zero, sets drive and frame rate
// RQ16 - drive 2048/(4n) for 2x, 2048/(2n) for 3x/4x, 3x capped, code 0 is n=32
// RQ17 - frame rate is drive frequency divided by multiplex level
// RQ18 - blink enable bit in main config turns blinking on
// RQ19 - multiplex code 01 2x, 10 3x, 11 4x, 00 reserved
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "lcd_frame_defs.svh"

module lcd_frame_ctrl
  import lcd_frame_pkg::*;
#(
  parameter int unsigned LCD_TICK_CYCLES = `LCD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [1:0] display_screen_q,
  output logic display_on_q,
  output logic frame_invert_q,
  output logic [1:0] com_phase_q,
  output logic frame_start_q,
  output logic data_in_use_q,
  output logic irq_q
);

  // ==========================================================
  // registers
  main_config_t main_q;
  blink_clock_t clk_q;
  screen_ctrl_t ctrl_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_status_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_event;
  logic update_set;
  logic rotate_pulse;
  logic frame_edge;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      main_q <= `MAIN_CONFIG_RESET;
      clk_q <= `BLINK_CLOCK_RESET; // RQ15
      irq_mask_q <= `IRQ_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `MAIN_CONFIG_ADDR) begin
        main_q <= reg_wdata;
      end
      if (reg_addr == `BLINK_CLOCK_ADDR) begin
        clk_q <= reg_wdata;
      end
      if (reg_addr == `IRQ_MASK_ADDR) begin
        irq_mask_q <= reg_wdata[2:0];
      end
    end
  end

  // update-done: hardware set wins over a software write of zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_q <= `SCREEN_CTRL_RESET;
    end else begin
      if (reg_wr && reg_addr == `SCREEN_CTRL_ADDR) begin
        ctrl_q.auto_screen_rotate <= reg_wdata[7];
        ctrl_q.frame_invert_enable <= reg_wdata[6];
        ctrl_q.reserved <= reg_wdata[5:4];
        ctrl_q.screen_pick <= reg_wdata[3:2];
        ctrl_q.memory_hold <= reg_wdata[0];
        if (!reg_wdata[1]) begin
          ctrl_q.update_done_flag <= 1'b0;
        end
      end
      if (update_set) begin
        ctrl_q.update_done_flag <= 1'b1; // RQ7
      end
    end
  end

  // ==========================================================
  // interrupt status, cleared by read, set wins
  assign irq_event = {rotate_pulse, update_set, frame_edge};

  always_comb begin
    irq_status_d = irq_status_q;
    if (reg_rd && reg_addr == `IRQ_STATUS_ADDR) begin
      irq_status_d = 3'h0;
    end
    irq_status_d = irq_status_d | irq_event;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_status_q <= `IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  // ==========================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `MAIN_CONFIG_ADDR: reg_rdata <= main_q;
        `BLINK_CLOCK_ADDR: reg_rdata <= clk_q;
        `SCREEN_CTRL_ADDR: reg_rdata <= ctrl_q;
        `IRQ_STATUS_ADDR: reg_rdata <= {5'h00, irq_status_q};
        `IRQ_MASK_ADDR: reg_rdata <= {5'h00, irq_mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // 2048 Hz enable from the core clock
  logic [31:0] pre_cnt_q;
  logic lcd_tick;

  assign lcd_tick = (pre_cnt_q == LCD_TICK_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (!rst_b || lcd_tick) begin
      pre_cnt_q <= 32'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // drive frequency divider and common phase
  logic [7:0] div_n;
  logic [7:0] divisor;
  logic [7:0] div_cnt_q;
  logic [1:0] last_phase;
  logic drive_tick;

  always_comb begin
    div_n = (clk_q.frame_divider_code == 4'h0) ? `DIV_CODE_ZERO_N
          : {4'h0, clk_q.frame_divider_code} + 8'h01; // RQ16
    if (main_q.multiplex_level == `MUX_3X || main_q.multiplex_level == `MUX_4X) begin
      divisor = 8'(div_n * `DIV_MULT_3X4X); // RQ16
    end else begin
      divisor = 8'(div_n * `DIV_MULT_2X); // RQ16
    end
    if (main_q.multiplex_level == `MUX_3X && divisor < `DIV_MIN_3X) begin
      divisor = `DIV_MIN_3X; // RQ16
    end
  end

  // reserved code 00 runs like 2x so the panel never sees a stuck common
  always_comb begin
    unique case (main_q.multiplex_level)
      `MUX_3X: last_phase = 2'h2; // RQ19
      `MUX_4X: last_phase = 2'h3; // RQ19
      default: last_phase = 2'h1; // RQ19
    endcase
  end

  assign drive_tick = lcd_tick && (div_cnt_q >= divisor - 8'h01);
  assign frame_edge = drive_tick && (com_phase_q >= last_phase); // RQ17

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_cnt_q <= 8'h00;
    end else if (drive_tick) begin
      div_cnt_q <= 8'h00;
    end else if (lcd_tick) begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      com_phase_q <= 2'h0;
      frame_start_q <= 1'b0;
    end else begin
      frame_start_q <= frame_edge;
      if (frame_edge) begin
        com_phase_q <= 2'h0; // RQ17
      end else if (drive_tick) begin
        com_phase_q <= com_phase_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // frame inversion
  always_ff @(posedge core_clk) begin
    if (!rst_b || !ctrl_q.frame_invert_enable) begin
      frame_invert_q <= 1'b0; // RQ4
    end else if (frame_edge) begin
      frame_invert_q <= !frame_invert_q; // RQ4
    end
  end

  // ==========================================================
  // quarter-second time base for blink and rotation
  logic [9:0] qtr_cnt_q;
  logic qtr_tick;
  logic [3:0] blink_cnt_q;
  logic [3:0] rot_cnt_q;
  logic [3:0] blink_half;
  logic [3:0] rot_period;
  logic blink_phase_q;
  logic blink_2hz_q;

  assign qtr_tick = lcd_tick && (qtr_cnt_q == `QUARTER_SEC_TICKS - 10'h001);
  // half period 2,4,6,8 quarters gives 1, 1/2, 1/3, 1/4 Hz
  assign blink_half = {1'b0, clk_q.blink_rate_code, 1'b0} + 4'h2; // RQ14
  // one screen per full blink period of the rate code
  assign rot_period = {clk_q.blink_rate_code, 2'h0} + 4'h4; // RQ2
  assign rotate_pulse = ctrl_q.auto_screen_rotate && qtr_tick
                        && (rot_cnt_q >= rot_period - 4'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_b || (lcd_tick && qtr_tick)) begin
      qtr_cnt_q <= 10'h000;
    end else if (lcd_tick) begin
      qtr_cnt_q <= qtr_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      blink_cnt_q <= 4'h0;
      blink_phase_q <= 1'b1;
      blink_2hz_q <= 1'b1;
    end else if (qtr_tick) begin
      blink_2hz_q <= !blink_2hz_q; // RQ12
      if (blink_cnt_q >= blink_half - 4'h1) begin
        blink_cnt_q <= 4'h0;
        blink_phase_q <= !blink_phase_q; // RQ13
      end else begin
        blink_cnt_q <= blink_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !ctrl_q.auto_screen_rotate) begin
      rot_cnt_q <= 4'h0;
    end else if (rotate_pulse) begin
      rot_cnt_q <= 4'h0;
    end else if (qtr_tick) begin
      rot_cnt_q <= rot_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // screen selection; rotation starts from the screen shown before it, a pick written with the rotate bit is not used
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      display_screen_q <= 2'h0;
    end else if (!ctrl_q.auto_screen_rotate) begin
      display_screen_q <= ctrl_q.screen_pick; // RQ6
    end else if (rotate_pulse) begin
      display_screen_q <= display_screen_q + 2'h1; // RQ1
    end
  end

  // ==========================================================
  // display visibility
  logic blink_visible;

  always_comb begin
    unique case (clk_q.blink_source)
      `BLINK_SRC_OFF: blink_visible = 1'b0; // RQ10
      `BLINK_SRC_ON: blink_visible = 1'b1; // RQ11
      `BLINK_SRC_2HZ: blink_visible = blink_2hz_q; // RQ12
      `BLINK_SRC_RATE: blink_visible = blink_phase_q; // RQ13
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      display_on_q <= 1'b0;
    end else if (!main_q.blink_enable || ctrl_q.auto_screen_rotate) begin
      display_on_q <= main_q.lcd_enable; // RQ3
    end else begin
      display_on_q <= main_q.lcd_enable && blink_visible; // RQ18
    end
  end

  // ==========================================================
  // memory hold handshake
  mem_state_t mem_state_q;

  assign update_set = (mem_state_q == MEM_WAIT_FRAME) && !ctrl_q.memory_hold && frame_edge;

  // a hold set again while waiting returns straight to held
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_state_q <= MEM_IN_USE;
      data_in_use_q <= 1'b1;
    end else begin
      unique case (mem_state_q)
        MEM_IN_USE: begin
          if (ctrl_q.memory_hold) begin
            mem_state_q <= MEM_HELD;
            data_in_use_q <= 1'b0; // RQ8
          end
        end
        MEM_HELD: begin
          if (!ctrl_q.memory_hold) begin
            mem_state_q <= MEM_WAIT_FRAME;
          end
        end
        MEM_WAIT_FRAME: begin
          if (ctrl_q.memory_hold) begin
            mem_state_q <= MEM_HELD;
          end else if (frame_edge) begin
            mem_state_q <= MEM_IN_USE;
            data_in_use_q <= 1'b1; // RQ9
          end
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  rotate_step_a: assert property (rotate_pulse && $past(ctrl_q.auto_screen_rotate) // RQ1
      |=> display_screen_q == 2'($past(display_screen_q) + 2'h1))
    else $error("auto rotation did not step the screen");

  rotate_interval_a: assert property (rotate_pulse |-> rot_cnt_q == rot_period - 4'h1) // RQ2
    else $error("rotation interval wrong");

  rotate_priority_a: assert property (ctrl_q.auto_screen_rotate && main_q.lcd_enable // RQ3
      |=> display_on_q)
    else $error("blink not suppressed during rotation");

  invert_off_a: assert property (!ctrl_q.frame_invert_enable |=> !frame_invert_q) // RQ4
    else $error("inverted frame while inversion disabled");

  invert_toggle_a: assert property (ctrl_q.frame_invert_enable && frame_edge // RQ4
      ##1 ctrl_q.frame_invert_enable |-> frame_invert_q != $past(frame_invert_q))
    else $error("inversion did not toggle at frame");

  pick_screen_a: assert property (!ctrl_q.auto_screen_rotate // RQ6
      |=> display_screen_q == $past(ctrl_q.screen_pick))
    else $error("displayed screen not the picked one");

  update_done_a: assert property ($rose(data_in_use_q) |-> ctrl_q.update_done_flag // RQ7
      && $past(frame_edge))
    else $error("memory reuse without update flag at frame start");

  hold_stop_a: assert property (ctrl_q.memory_hold |=> !data_in_use_q) // RQ8
    else $error("display used memory while held");

  blink_off_a: assert property (main_q.blink_enable && !ctrl_q.auto_screen_rotate // RQ10
      && clk_q.blink_source == `BLINK_SRC_OFF |=> !display_on_q)
    else $error("display on with blink source off");

  blink_on_a: assert property (main_q.blink_enable && main_q.lcd_enable // RQ11
      && clk_q.blink_source == `BLINK_SRC_ON |=> display_on_q)
    else $error("display off with blink source on");

  cap_3x_a: assert property (main_q.multiplex_level == `MUX_3X // RQ16
      |-> divisor >= `DIV_MIN_3X && divisor == ((div_n < 8'h03) ? `DIV_MIN_3X : 8'(div_n * 2)))
    else $error("3x drive divisor wrong");

  frame_len_a: assert property (frame_edge |-> com_phase_q == last_phase) // RQ17
    else $error("frame not equal to multiplex level drive periods");

  rotate_c: cover property (rotate_pulse ##1 display_screen_q != $past(display_screen_q));
  resume_c: cover property (ctrl_q.memory_hold ##[1:300] update_set);
  blink_c: cover property (!ctrl_q.auto_screen_rotate && $changed(blink_phase_q));
  irq_c: cover property ($rose(irq_q));

endmodule : lcd_frame_ctrl

// ===== rtl/lcd_frame_defs.svh
// register map, field positions, reset values and timing constants of the lcd frame control
`ifndef LCD_FRAME_DEFS_SVH
`define LCD_FRAME_DEFS_SVH

// ==========================================================
// register offsets
`define MAIN_CONFIG_ADDR 8'h95
`define BLINK_CLOCK_ADDR 8'h96
`define SCREEN_CTRL_ADDR 8'hB1
`define IRQ_STATUS_ADDR 8'hB2
`define IRQ_MASK_ADDR 8'hB3

// ==========================================================
// reset values
`define MAIN_CONFIG_RESET 8'h01
`define BLINK_CLOCK_RESET 8'h00
`define SCREEN_CTRL_RESET 8'h00
`define IRQ_RESET 3'h0

// ==========================================================
// field codes
`define MUX_2X 2'h1
`define MUX_3X 2'h2
`define MUX_4X 2'h3
`define BLINK_SRC_OFF 2'h0
`define BLINK_SRC_ON 2'h1
`define BLINK_SRC_2HZ 2'h2
`define BLINK_SRC_RATE 2'h3
`define IRQ_FRAME_BIT 0
`define IRQ_UPDATE_BIT 1
`define IRQ_ROTATE_BIT 2

// ==========================================================
// timing
`define CORE_CLK_HZ 40000000
`define LCD_CLK_HZ 2048
`define LCD_TICK_CYCLES (`CORE_CLK_HZ / `LCD_CLK_HZ)
`define QUARTER_SEC_TICKS 10'h200
`define DIV_CODE_ZERO_N 8'h20
`define DIV_MULT_2X 8'h04
`define DIV_MULT_3X4X 8'h02
`define DIV_MIN_3X 8'h06

`endif

// ===== rtl/lcd_frame_pkg.sv
// types shared by the lcd frame control
package lcd_frame_pkg;

  typedef struct packed {
    logic lcd_enable;
    logic clear_data;
    logic blink_enable;
    logic sleep_off;
    logic clock_select;
    logic bias_third;
    logic [1:0] multiplex_level;
  } main_config_t;

  typedef struct packed {
    logic [1:0] blink_source;
    logic [1:0] blink_rate_code;
    logic [3:0] frame_divider_code;
  } blink_clock_t;

  typedef struct packed {
    logic auto_screen_rotate;
    logic frame_invert_enable;
    logic [1:0] reserved;
    logic [1:0] screen_pick;
    logic update_done_flag;
    logic memory_hold;
  } screen_ctrl_t;

  typedef enum logic [1:0] {MEM_IN_USE, MEM_HELD, MEM_WAIT_FRAME} mem_state_t;

endpackage : lcd_frame_pkg

// ===== verification/lcd_glass_model.sv
// lcd glass model: watches the common drive and reports frame length
`timescale 1ns/1ps

// ==========================================================
// glass panel
module lcd_glass_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] com_phase_q,
  input wire logic frame_start_q,
  output int frame_cycles,
  output int frame_phases
);
  int cnt;
  int top;

  // glass is passive: it only counts what the commons and frame pulse show
  always @(posedge core_clk) begin
    if (!rst_b) begin
      cnt = 0;
      top = 0;
      frame_cycles = 0;
      frame_phases = 0;
    end else if (frame_start_q) begin
      frame_cycles = cnt + 1;
      frame_phases = top + 1;
      cnt = 0;
      top = 0;
    end else begin
      cnt = cnt + 1;
      if (int'(com_phase_q) > top) begin
        top = int'(com_phase_q);
      end
    end
  end
endmodule : lcd_glass_model

// ===== verification/lcd_screen_blink_frame_control_tb.sv
// self-checking bench for the lcd screen, blink and frame control
`timescale 1ns/1ps

// ==========================================================
// bench
module lcd_screen_blink_frame_control_tb;
  import lcd_frame_pkg::*;
  localparam int TICK = 4;
  localparam int QTR = 512 * TICK;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] v;
  logic [1:0] display_screen_q, com_phase_q, mx, s;
  logic display_on_q, frame_invert_q, frame_start_q, data_in_use_q, irq_q;
  int frame_cycles, frame_phases, mismatches, checked, cyc, seed, n, fd, div;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];

  always #12.5 core_clk = ~core_clk;

  lcd_frame_ctrl #(.LCD_TICK_CYCLES(TICK)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .display_screen_q(display_screen_q), .display_on_q(display_on_q),
    .frame_invert_q(frame_invert_q), .com_phase_q(com_phase_q),
    .frame_start_q(frame_start_q), .data_in_use_q(data_in_use_q), .irq_q(irq_q));

  lcd_glass_model i_glass (
    .core_clk(core_clk), .rst_b(rst_b), .com_phase_q(com_phase_q),
    .frame_start_q(frame_start_q), .frame_cycles(frame_cycles),
    .frame_phases(frame_phases));

  // ==========================================================
  // reporting
  task automatic summarize;
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
    chk(got & m, e & m);
  endtask : chk_rd

  // ==========================================================
  // register bus and waits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wait_frame;
    n = 0;
    @(posedge core_clk);
    while (frame_start_q !== 1'b1 && n < 5000) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 5000) begin
      mismatches++;
    end
    #1;
  endtask : wait_frame

  // bounded: a stuck output ends the wait and shows as a wrong interval
  task automatic wait_change(input logic scr, output int c);
    logic [1:0] w;
    w = scr ? display_screen_q : {1'b0, display_on_q};
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while ((scr ? display_screen_q : {1'b0, display_on_q}) === w && c < 40000);
  endtask : wait_change

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen) begin
      chk_rd(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
    end
    rd_seen <= reg_rd;
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    seed = 94;
    mismatches = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    chk(8'(data_in_use_q), 8'h01);
    rd(8'h95, 8'h01, 8'hFF);
    rd(8'h96, 8'h00, 8'hFF);
    rd(8'hB1, 8'h00, 8'hFF);
    rd(8'hB2, 8'h00, 8'hFF);
    rd(8'hB3, 8'h00, 8'hFF);
    v = 8'($random(seed));
    wr(8'h96, v);
    wr(8'h42, 8'hFF);
    rd(8'h96, v, 8'hFF);
    rd(8'h42, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      mx = (i == 0) ? 2'h1 : i[1:0];
      fd = (i == 0) ? 0 : 1;
      wr(8'h95, {6'h20, mx});
      wr(8'h96, 8'(fd));
      div = (fd == 0) ? 32 : fd + 1;
      div = (mx == 2'h1) ? 4 * div : 2 * div;
      if (mx == 2'h2 && div < 6) begin
        div = 6;
      end
      repeat (3) wait_frame;
      chk_cnt(frame_cycles, div * (int'(mx) + 1) * TICK);
      chk_cnt(frame_phases, int'(mx) + 1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'hB1, {4'h0, i[1:0], 2'h0});
      repeat (2) @(posedge core_clk);
      chk(8'(display_screen_q), 8'(i));
    end
    wr(8'hB1, 8'h40);
    wait_frame;
    v = 8'(frame_invert_q);
    wait_frame;
    chk(8'(frame_invert_q), {7'h00, ~v[0]});
    wr(8'hB1, 8'h00);
    repeat (2) wait_frame;
    chk(8'(frame_invert_q), 8'h00);
    wait_frame;
    wr(8'hB1, 8'h01);
    repeat (2) @(posedge core_clk);
    chk(8'(data_in_use_q), 8'h00);
    rd(8'hB1, 8'h01, 8'h01);
    wr(8'hB1, 8'h00);
    @(posedge core_clk);
    chk(8'(data_in_use_q), 8'h00);
    wait_frame;
    chk(8'(data_in_use_q), 8'h01);
    rd(8'hB1, 8'h02, 8'h03);
    wr(8'hB3, 8'h01);
    wait_frame;
    chk(8'(irq_q), 8'h01);
    rd(8'hB2, 8'h03, 8'h03);
    repeat (3) @(posedge core_clk);
    chk(8'(irq_q), 8'h00);
    wr(8'hB3, 8'h00);
    wait_frame;
    @(posedge core_clk);
    chk(8'(irq_q), 8'h00);
    wr(8'h95, 8'hA3);
    wr(8'h96, 8'h01);
    repeat (2) @(posedge core_clk);
    chk(8'(display_on_q), 8'h00);
    wr(8'h96, 8'h41);
    repeat (2) @(posedge core_clk);
    chk(8'(display_on_q), 8'h01);
    // rate code set to 3 here must not change the fixed rate
    wr(8'h96, 8'hB1);
    // a source switch may flip the display at once, so the third gap is the full one
    repeat (3) wait_change(1'b0, n);
    chk_cnt(n, QTR);
    for (int k = 0; k < 2; k++) begin
      wr(8'h96, 8'(8'hC1 | (k << 4)));
      repeat (3) wait_change(1'b0, n);
      chk_cnt(n, 2 * (k + 1) * QTR);
    end
    wr(8'h96, 8'h01);
    wr(8'hB1, 8'h88);
    repeat (2) @(posedge core_clk);
    chk(8'(display_on_q), 8'h01);
    wait_change(1'b1, n);
    s = display_screen_q;
    wait_change(1'b1, n);
    chk_cnt(n, 4 * QTR);
    chk(8'(display_screen_q), {6'h00, s + 2'h1});
    summarize();
  end
endmodule : lcd_screen_blink_frame_control_tb
